// >>> logic/afflag_top.sv
// Analog fault flag register with sticky write-one-to-clear flags
//
// Overview of operation
// - Flags stay latched; host writes one to clear
// - Disabled diagnostic flags read as zero
// - Bit 21 reads inverted alarm pin level
// - Address 0x15, reset 0x150000, bits[20:16] address
// - Bit 13 latches on output rail overrange
// - Bit 11 latches on converter short
// - Bit 9 latches on converter regulation fault
// - Bit 7 latches on open or headroom loss
// - Bit 6 latches on voltage output short
// - Bits 5 and 4 latch on die overtemperature
// - Bit 3 latches on reference output fault
// - Bit 2 latches on reference input fault
// - Bit 1 latches on internal supply fault
// - Bit 0 latches on regulator node fault
// - Summary bit equals OR of bits[13:0]
`timescale 1ns/1ps
`default_nettype none
module afflag_top
    import afflag_pkg::*;
(
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    // Register port
    input wire logic I_WR_EN,
    input wire logic I_RD_EN,
    input wire logic [4:0] I_ADDR,
    input wire logic [AF_WIDTH-1:0] I_WDATA,
    output logic [AF_WIDTH-1:0] O_RDATA,
    output logic O_RD_VALID,
    // Monitors and enables
    input wire afflag_mon_s I_MON,
    input wire logic [AF_NFLAGS-1:0] I_DIAG_EN,
    input wire logic I_ALARM_PIN,
    // Status
    output logic O_ANALOG_FAULT_SUMMARY
);

    // ****************************************
    // Flag storage
    // ****************************************
    logic [AF_NFLAGS-1:0] flags_reg;
    logic [AF_NFLAGS-1:0] flags_next;
    logic [AF_NFLAGS-1:0] raw_events;
    logic [AF_NFLAGS-1:0] clear_bits;
    logic [AF_NFLAGS-1:0] visible;

    function automatic logic [AF_NFLAGS-1:0] map_events(input afflag_mon_s m);
        logic [AF_NFLAGS-1:0] e;
        e = '0;
        e[AF_B_OVR] = m.output_rail_overrange;
        e[AF_B_CSC] = m.converter_short;
        e[AF_B_CREG] = m.converter_regulation;
        e[AF_B_IOPEN] = m.current_open | m.current_headroom;
        e[AF_B_VSHORT] = m.voltage_short;
        e[AF_B_CDIE] = m.converter_die_overtemp;
        e[AF_B_MDIE] = m.main_die_overtemp;
        e[AF_B_REFOUT] = m.ref_output_window | m.ref_output_limit;
        e[AF_B_REFIN] = m.ref_input_window;
        e[AF_B_SUPPLY] = m.internal_supply_window;
        e[AF_B_REG] = m.regulator_window | m.regulator_limit;
        return e;
    endfunction

    always_comb begin
        raw_events = map_events(I_MON) & I_DIAG_EN & AF_FLAG_MASK;
        clear_bits = '0;
        if (I_WR_EN && I_ADDR == AF_ADDR) begin
            clear_bits = I_WDATA[AF_FLAG_TOP:0] & AF_FLAG_MASK;
        end
        // Set wins over clear so a live fault is never lost
        flags_next = ((flags_reg & ~clear_bits) | raw_events) & AF_FLAG_MASK;
        visible = flags_reg & I_DIAG_EN;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [AF_WIDTH-1:0] rdata_reg;
    logic [AF_WIDTH-1:0] rdata_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic summary_reg;
    logic summary_next;

    always_comb begin
        rdata_next = rdata_reg;
        rd_valid_next = I_RD_EN;
        if (I_RD_EN) begin
            rdata_next = '0;
            rdata_next[AF_FLAG_TOP:0] = visible;
            rdata_next[AF_ADDR_LSB +: 5] = AF_ADDR;
            rdata_next[AF_ALARM_BIT] = ~I_ALARM_PIN;
        end
        summary_next = |visible;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdata_reg <= AF_RESET;
            rd_valid_reg <= 1'b0;
            summary_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rd_valid_reg <= rd_valid_next;
            summary_reg <= summary_next;
        end
    end

    assign O_RDATA = rdata_reg;
    assign O_RD_VALID = rd_valid_reg;
    assign O_ANALOG_FAULT_SUMMARY = summary_reg;

    // ****************************************
    // Checks
    // ****************************************
    AST_STICKY: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_CSC] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_CSC]) |=> flags_reg[AF_B_CSC])
        else $error("flag dropped without clear");
    AST_MASKED: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_RD_EN && !I_DIAG_EN[AF_B_REFIN] && !I_DIAG_EN[AF_B_REFIN] |=> !O_RDATA[AF_B_REFIN])
        else $error("disabled flag read nonzero");
    AST_ALARM: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_RD_EN |=> O_RDATA[AF_ALARM_BIT] == !$past(I_ALARM_PIN))
        else $error("alarm bit not inverted pin");
    AST_ADDR: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_RD_EN |=> O_RDATA[20:16] == 5'h15 && O_RD_VALID)
        else $error("address field wrong");
    AST_OVR: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.output_rail_overrange && I_DIAG_EN[AF_B_OVR] |=> flags_reg[AF_B_OVR])
        else $error("overrange not latched");
    AST_OPEN: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.current_headroom && I_DIAG_EN[AF_B_IOPEN] |=> flags_reg[AF_B_IOPEN])
        else $error("headroom not latched");
    AST_REF: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.ref_output_limit && I_DIAG_EN[AF_B_REFOUT] |=> flags_reg[AF_B_REFOUT])
        else $error("ref limit not latched");
    AST_REG: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.regulator_limit && I_DIAG_EN[AF_B_REG] |=> flags_reg[AF_B_REG])
        else $error("regulator limit not latched");
    AST_SUMMARY: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        ##1 O_ANALOG_FAULT_SUMMARY == |$past(visible))
        else $error("summary mismatch");
    AST_PERSIST: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_MON.voltage_short && I_DIAG_EN[AF_B_VSHORT] |=> flags_reg[AF_B_VSHORT])
        else $error("live fault cleared");
    AST_RSVD: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_RD_EN |=> O_RDATA[15:14] == 2'h0 && !O_RDATA[12] && !O_RDATA[10] && !O_RDATA[8])
        else $error("reserved bit nonzero");

    // ****************************************
    // Per-flag checks, set, clear, hold and read masking
    // ****************************************
    AST_SET_CSC: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.converter_short && I_DIAG_EN[AF_B_CSC] |=> flags_reg[AF_B_CSC])
        else $error("converter short not latched");

    AST_SET_CREG: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.converter_regulation && I_DIAG_EN[AF_B_CREG] |=> flags_reg[AF_B_CREG])
        else $error("regulation fault not latched");

    AST_SET_IOPEN: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.current_open && I_DIAG_EN[AF_B_IOPEN] |=> flags_reg[AF_B_IOPEN])
        else $error("open circuit not latched");

    AST_SET_VSHORT: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.voltage_short && I_DIAG_EN[AF_B_VSHORT] |=> flags_reg[AF_B_VSHORT])
        else $error("voltage short not latched");

    AST_SET_CDIE: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.converter_die_overtemp && I_DIAG_EN[AF_B_CDIE] |=> flags_reg[AF_B_CDIE])
        else $error("converter die heat not latched");

    AST_SET_MDIE: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.main_die_overtemp && I_DIAG_EN[AF_B_MDIE] |=> flags_reg[AF_B_MDIE])
        else $error("main die heat not latched");

    AST_SET_REFOUT: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.ref_output_window && I_DIAG_EN[AF_B_REFOUT] |=> flags_reg[AF_B_REFOUT])
        else $error("ref output window not latched");

    AST_SET_REFIN: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.ref_input_window && I_DIAG_EN[AF_B_REFIN] |=> flags_reg[AF_B_REFIN])
        else $error("ref input not latched");

    AST_SET_SUPPLY: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.internal_supply_window && I_DIAG_EN[AF_B_SUPPLY] |=> flags_reg[AF_B_SUPPLY])
        else $error("supply node not latched");

    AST_SET_REG: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_MON.regulator_window && I_DIAG_EN[AF_B_REG] |=> flags_reg[AF_B_REG])
        else $error("regulator window not latched");

    AST_CLR_OVR: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_OVR] && !raw_events[AF_B_OVR] |=> !flags_reg[AF_B_OVR])
        else $error("flag not cleared");

    AST_CLR_CSC: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_CSC] && !raw_events[AF_B_CSC] |=> !flags_reg[AF_B_CSC])
        else $error("flag not cleared");

    AST_CLR_CREG: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_CREG] && !raw_events[AF_B_CREG] |=> !flags_reg[AF_B_CREG])
        else $error("flag not cleared");

    AST_CLR_IOPEN: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_IOPEN] && !raw_events[AF_B_IOPEN] |=> !flags_reg[AF_B_IOPEN])
        else $error("flag not cleared");

    AST_CLR_VSHORT: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_VSHORT] && !raw_events[AF_B_VSHORT] |=> !flags_reg[AF_B_VSHORT])
        else $error("flag not cleared");

    AST_CLR_CDIE: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_CDIE] && !raw_events[AF_B_CDIE] |=> !flags_reg[AF_B_CDIE])
        else $error("flag not cleared");

    AST_CLR_MDIE: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_MDIE] && !raw_events[AF_B_MDIE] |=> !flags_reg[AF_B_MDIE])
        else $error("flag not cleared");

    AST_CLR_REFOUT: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_REFOUT] && !raw_events[AF_B_REFOUT] |=> !flags_reg[AF_B_REFOUT])
        else $error("flag not cleared");

    AST_CLR_REFIN: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_REFIN] && !raw_events[AF_B_REFIN] |=> !flags_reg[AF_B_REFIN])
        else $error("flag not cleared");

    AST_CLR_SUPPLY: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_SUPPLY] && !raw_events[AF_B_SUPPLY] |=> !flags_reg[AF_B_SUPPLY])
        else $error("flag not cleared");

    AST_CLR_REG: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_REG] && !raw_events[AF_B_REG] |=> !flags_reg[AF_B_REG])
        else $error("flag not cleared");

    AST_HOLD_OVR: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_OVR] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_OVR]) |=> flags_reg[AF_B_OVR])
        else $error("flag dropped without clear");

    AST_HOLD_CREG: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_CREG] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_CREG]) |=> flags_reg[AF_B_CREG])
        else $error("flag dropped without clear");

    AST_HOLD_IOPEN: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_IOPEN] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_IOPEN]) |=> flags_reg[AF_B_IOPEN])
        else $error("flag dropped without clear");

    AST_HOLD_VSHORT: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_VSHORT] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_VSHORT]) |=> flags_reg[AF_B_VSHORT])
        else $error("flag dropped without clear");

    AST_HOLD_CDIE: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_CDIE] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_CDIE]) |=> flags_reg[AF_B_CDIE])
        else $error("flag dropped without clear");

    AST_HOLD_MDIE: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_MDIE] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_MDIE]) |=> flags_reg[AF_B_MDIE])
        else $error("flag dropped without clear");

    AST_HOLD_REFOUT: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_REFOUT] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_REFOUT]) |=> flags_reg[AF_B_REFOUT])
        else $error("flag dropped without clear");

    AST_HOLD_REFIN: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_REFIN] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_REFIN]) |=> flags_reg[AF_B_REFIN])
        else $error("flag dropped without clear");

    AST_HOLD_SUPPLY: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_SUPPLY] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_SUPPLY]) |=> flags_reg[AF_B_SUPPLY])
        else $error("flag dropped without clear");

    AST_HOLD_REG: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        flags_reg[AF_B_REG] && !(I_WR_EN && I_ADDR == AF_ADDR && I_WDATA[AF_B_REG]) |=> flags_reg[AF_B_REG])
        else $error("flag dropped without clear");

    AST_MASK_OVR: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_RD_EN && !I_DIAG_EN[AF_B_OVR] |=> !O_RDATA[AF_B_OVR])
        else $error("disabled flag read nonzero");

    AST_MASK_IOPEN: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_RD_EN && !I_DIAG_EN[AF_B_IOPEN] |=> !O_RDATA[AF_B_IOPEN])
        else $error("disabled flag read nonzero");

    AST_MASK_REG: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_RD_EN && !I_DIAG_EN[AF_B_REG] |=> !O_RDATA[AF_B_REG])
        else $error("disabled flag read nonzero");

    // Reserved positions never hold state, so writes there cannot stick
    AST_RSVD_STORE: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        I_WR_EN |=> (flags_reg & ~AF_FLAG_MASK) == 14'h0000)
        else $error("reserved flag stored");

endmodule
`default_nettype wire

// >>> logic/afflag_pkg.sv
// Package for the analog fault flag register
package afflag_pkg;
    localparam int AF_WIDTH = 22;
    localparam logic [4:0] AF_ADDR = 5'h15;
    localparam logic [21:0] AF_RESET = 22'h150000;
    localparam int AF_ALARM_BIT = 21;
    localparam int AF_ADDR_LSB = 16;
    localparam int AF_FLAG_TOP = 13;
    localparam int AF_NFLAGS = 14;
    localparam int AF_B_OVR = 13;
    localparam int AF_B_CSC = 11;
    localparam int AF_B_CREG = 9;
    localparam int AF_B_IOPEN = 7;
    localparam int AF_B_VSHORT = 6;
    localparam int AF_B_CDIE = 5;
    localparam int AF_B_MDIE = 4;
    localparam int AF_B_REFOUT = 3;
    localparam int AF_B_REFIN = 2;
    localparam int AF_B_SUPPLY = 1;
    localparam int AF_B_REG = 0;
    localparam logic [13:0] AF_FLAG_MASK = 14'h2AFF;

    // Raw monitor indications, one per source condition
    typedef struct packed {
        logic output_rail_overrange;
        logic converter_short;
        logic converter_regulation;
        logic current_open;
        logic current_headroom;
        logic voltage_short;
        logic converter_die_overtemp;
        logic main_die_overtemp;
        logic ref_output_window;
        logic ref_output_limit;
        logic ref_input_window;
        logic internal_supply_window;
        logic regulator_window;
        logic regulator_limit;
    } afflag_mon_s;
endpackage

// >>> testbench/afflag_host.sv
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module afflag_host
    import afflag_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic wr_en,
    output logic rd_en,
    output logic [4:0] addr,
    output logic [AF_WIDTH-1:0] wdata,
    input wire logic [AF_WIDTH-1:0] rdata,
    input wire logic rd_valid
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 5'h00;
        wdata = '0;
    end
    // Released bus shows inverse so stale values never match
    task automatic write(input logic [4:0] a, input logic [AF_WIDTH-1:0] d);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    task automatic read(output logic [AF_WIDTH-1:0] d, output logic ok);
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        ok = 1'b0;
        d = '0;
        for (int i = 0; i < 3 && !ok; i++) begin
            if (rd_valid === 1'b1) begin
                d = rdata;
                ok = 1'b1;
            end else begin
                @(negedge clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/afflag_top_tb.sv
// Self-checking bench for the analog fault flag register
`timescale 1ns/1ps
`default_nettype none
module afflag_top_tb;
    import afflag_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, pin = 1'b1, wr, rd, ok, rv, summ;
    logic [4:0] addr, a_r;
    logic [21:0] wd, rdat, got, d_r;
    logic [13:0] en = '1, exp = '0, clr;
    afflag_mon_s mon = '0;
    int seed = 19983, miscompares = 0, tests_run = 0;
    always #5 clk = ~clk;
    afflag_top DUT (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_WR_EN(wr), .I_RD_EN(rd), .I_ADDR(addr), .I_WDATA(wd),
        .O_RDATA(rdat), .O_RD_VALID(rv), .I_MON(mon), .I_DIAG_EN(en), .I_ALARM_PIN(pin),
        .O_ANALOG_FAULT_SUMMARY(summ));
    afflag_host HOST (.clk(clk), .wr_en(wr), .rd_en(rd), .addr(addr), .wdata(wd), .rdata(rdat), .rd_valid(rv));
    function automatic logic [13:0] map(afflag_mon_s s);
        return {s.output_rail_overrange, 1'b0, s.converter_short, 1'b0, s.converter_regulation, 1'b0,
            s.current_open | s.current_headroom, s.voltage_short, s.converter_die_overtemp, s.main_die_overtemp,
            s.ref_output_window | s.ref_output_limit, s.ref_input_window, s.internal_supply_window,
            s.regulator_window | s.regulator_limit};
    endfunction
    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(string n, logic [21:0] e, logic [21:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic read_chk();
        HOST.read(got, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            close_out();
        end
        check("read", {~pin, AF_ADDR, 2'b00, exp & en}, got);
        check("summary", 22'(|(exp & en)), 22'(summ));
    endtask
    // ************
    // Main sequence
    // ************
    initial begin
        repeat (8) @(negedge clk);
        check("reset", AF_RESET, rdat);
        rst_n = 1'b1;
        @(negedge clk);
        read_chk();
        // Each source alone, cleared while present, then cleared after
        for (int b = 0; b < 14; b++) begin
            mon = afflag_mon_s'(14'h1 << b);
            exp = map(mon);
            HOST.write(AF_ADDR, '1);
            mon = '0;
            read_chk();
            HOST.write(AF_ADDR, {8'h00, exp});
            exp = '0;
            read_chk();
        end
        $display("Test done: per-flag");
        // Random events, enables, pin and writes, some to other addresses
        for (int i = 0; i < 300; i++) begin
            mon = afflag_mon_s'(14'($random(seed) & $random(seed) & $random(seed)));
            en = 14'($random(seed));
            pin = 1'($random(seed));
            a_r = ($random(seed) & 1) ? AF_ADDR : 5'($random(seed));
            d_r = 22'($random(seed));
            clr = (a_r == AF_ADDR) ? d_r[13:0] : 14'h0000;
            exp = (exp & ~clr) | (map(mon) & en);
            HOST.write(a_r, d_r);
            mon = '0;
            read_chk();
        end
        $display("Test done: random");
        close_out();
    end
endmodule
`default_nettype wire
